// [rtl/crg_pkg.sv]
// Constants for the CPU register file and change guard block
package crg_pkg;
  localparam int            NUM_REGS         = 32;
  localparam int            REG_W            = 8;
  localparam logic [4:0]    PTR1_LO          = 5'h1A;
  localparam logic [4:0]    PTR2_LO          = 5'h1C;
  localparam logic [4:0]    PTR3_LO          = 5'h1E;
  localparam logic [5:0]    OFS_GUARD        = 6'h04;
  localparam logic [5:0]    OFS_SP_LO        = 6'h0D;
  localparam logic [5:0]    OFS_SP_HI        = 6'h0E;
  localparam logic [5:0]    OFS_FLAGS        = 6'h0F;
  localparam logic [5:0]    OFS_TEMP         = 6'h10;
  localparam logic [7:0]    SIG_SELF_PROG    = 8'h9D;
  localparam logic [7:0]    SIG_IO_UNLOCK    = 8'hD8;
  localparam int            GUARD_IO_BIT     = 0;
  localparam int            GUARD_SP_BIT     = 1;
  localparam logic [2:0]    GUARD_INSNS      = 3'h4;
  localparam logic [15:0]   SP_RESET         = 16'h37FF;
  localparam logic [7:0]    FLAGS_RESET      = 8'h00;
  localparam logic [1:0]    MODE_DISP        = 2'h0;
  localparam logic [1:0]    MODE_POSTINC     = 2'h1;
  localparam logic [1:0]    MODE_PREDEC      = 2'h2;
  typedef enum logic [1:0] {CRG_IDLE, CRG_IO_OPEN, CRG_SP_OPEN} crg_guard_t;
endpackage : crg_pkg

// [rtl/crg_core.sv]
// CPU working register file, pointer pairs, 16-bit access latch and change guard
`timescale 1ns/100ps
// How it works
// - Thirty-two byte registers, read combinationally and written in one cycle.
// - Byte reads on two ports, word reads on port A only; byte or word result writes.
// - Indices 0x1A..0x1F also form three 16-bit pointer pairs.
// - Lower index is pointer bits 7:0, higher index bits 15:8.
// - Loads/stores pick any pointer; program load, indirect call and jump use third.
// - Pointers give displacement, post-increment and pre-decrement addressing.
// - Working registers live apart; the I/O bus cannot reach them.
// - Low byte write is held; high byte write commits both at once.
// - Low byte read copies high byte to temp; high read returns it.
// - The temporary byte is directly readable and writable.
// - Protected writes and self-programming blocked without a valid signature.
// - I/O window closes on data or I/O bus write, flash/controller/EEPROM access, sleep, or after four instructions.
// - Self-program window lasts four instructions; cancelled by flash access, sleep or a self-programming instruction.
// - Interrupts held off while a window is open, including non-maskable ones.
// - Debug port reads and writes registers while halted, then resumes.
// - 0x9D opens self-programming; 0xD8 unlocks protected I/O.
// - Guard bit 0 shows I/O window, bit 1 self-program window, rest zero.
module crg_core #(
  parameter int AW = 6
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // Operand read ports
  input  wire logic [4:0]    rd_a_idx,
  input  wire logic [4:0]    rd_b_idx,
  output logic      [7:0]    rd_a_data,
  output logic      [7:0]    rd_b_data,
  output logic      [15:0]   rd_word_data,
  // Result write port
  input  wire logic          wr_byte_en,
  input  wire logic          wr_word_en,
  input  wire logic [4:0]    wr_idx,
  input  wire logic [15:0]   wr_data,
  // Pointer addressing
  input  wire logic [1:0]    ptr_sel,
  input  wire logic [1:0]    ptr_mode,
  input  wire logic [5:0]    ptr_disp,
  input  wire logic          ptr_use,
  input  wire logic          prog_ptr_use,
  output logic      [15:0]   ptr_addr,
  output logic      [15:0]   prog_addr,
  // Instruction events
  input  wire logic          insn_done,
  input  wire logic          data_write,
  input  wire logic          nvm_access,
  input  wire logic          sleep_exec,
  input  wire logic          spm_exec,
  input  wire logic          prot_write_req,
  output logic               prot_write_ok,
  output logic               spm_ok,
  output logic               irq_hold,
  // Peripheral I/O bus
  input  wire logic          io_wr,
  input  wire logic          io_rd,
  input  wire logic [AW-1:0] io_addr,
  input  wire logic [7:0]    io_wdata,
  output logic      [7:0]    io_rdata,
  output logic      [7:0]    flags,
  output logic      [15:0]   stack_pointer,
  // Debug access while halted
  input  wire logic          dbg_halt,
  input  wire logic          dbg_wr,
  input  wire logic [4:0]    dbg_idx,
  input  wire logic [7:0]    dbg_wdata,
  output logic      [7:0]    dbg_rdata
);
  logic [7:0]         regs_reg [crg_pkg::NUM_REGS];
  logic [7:0]         temp_reg;
  logic [15:0]        sp_reg;
  logic [7:0]         flags_reg;
  crg_pkg::crg_guard_t guard_reg;
  logic [2:0]         guard_cnt_reg;
  logic [7:0]         io_rdata_reg;
  wire logic [15:0]   ptr_pair [3];
  logic [15:0]        ptr_val;
  logic [15:0]        ptr_new;
  logic [15:0]        prog_ptr;
  logic [4:0]         ptr_lo_idx;
  logic               ptr_upd;
  logic               wr_guard;
  logic               sig_io;
  logic               sig_sp;
  logic               guard_cancel;
  logic               guard_tick;
  logic               guard_last;
  logic [7:0]         io_rd_mux;

  assign rd_a_data    = regs_reg[rd_a_idx];
  assign rd_b_data    = regs_reg[rd_b_idx];
  assign rd_word_data = {regs_reg[rd_a_idx | 5'h01], regs_reg[rd_a_idx & 5'h1E]};
  assign dbg_rdata    = regs_reg[dbg_idx];

  // The three pointer pairs, low byte at the even index
  genvar gp;
  generate
    for (gp = 0; gp < 3; gp = gp + 1)
    begin : g_ptr
      localparam logic [4:0] LO = crg_pkg::PTR1_LO + 5'(2 * gp);
      assign ptr_pair[gp] = {regs_reg[LO + 5'h01], regs_reg[LO]};
    end
  endgenerate

  always_comb
  begin
    case (ptr_sel)
      2'h0:
      begin
        ptr_lo_idx = crg_pkg::PTR1_LO;
        ptr_val    = ptr_pair[0];
      end
      2'h1:
      begin
        ptr_lo_idx = crg_pkg::PTR2_LO;
        ptr_val    = ptr_pair[1];
      end
      default:
      begin
        ptr_lo_idx = crg_pkg::PTR3_LO;
        ptr_val    = ptr_pair[2];
      end
    endcase
  end

  assign prog_ptr = ptr_pair[2];

  always_comb
  begin
    ptr_new  = ptr_val;
    ptr_addr = ptr_val;
    ptr_upd  = 1'b0;
    case (ptr_mode)
      crg_pkg::MODE_DISP:
      begin
        ptr_addr = ptr_val + {10'h000, ptr_disp};
      end
      crg_pkg::MODE_POSTINC:
      begin
        ptr_new = ptr_val + 16'h0001;
        ptr_upd = ptr_use;
      end
      crg_pkg::MODE_PREDEC:
      begin
        ptr_new  = ptr_val - 16'h0001;
        ptr_addr = ptr_new;
        ptr_upd  = ptr_use;
      end
      default:
      begin
        ptr_addr = ptr_val;
      end
    endcase
  end

  assign prog_addr = prog_ptr_use ? prog_ptr : 16'h0000;

  // Per-register next value; a result write beats a pointer update on the same register
  genvar gi;
  generate
    for (gi = 0; gi < crg_pkg::NUM_REGS; gi = gi + 1)
    begin : g_reg
      localparam logic [4:0] IDX = 5'(gi);
      logic       hit_dbg;
      logic       hit_word;
      logic       hit_byte;
      logic       hit_ptr;
      logic [7:0] cell_next;

      assign hit_dbg  = dbg_halt && dbg_wr && dbg_idx == IDX;
      assign hit_word = !dbg_halt && wr_word_en && (wr_idx & 5'h1E) == (IDX & 5'h1E);
      assign hit_byte = !dbg_halt && wr_byte_en && !wr_word_en && wr_idx == IDX;
      assign hit_ptr  = !dbg_halt && ptr_upd && ptr_lo_idx == (IDX & 5'h1E);

      always_comb
      begin
        cell_next = regs_reg[gi];
        if (hit_dbg)
          cell_next = dbg_wdata;
        else if (hit_word)
          cell_next = IDX[0] ? wr_data[15:8] : wr_data[7:0];
        else if (hit_byte)
          cell_next = wr_data[7:0];
        else if (hit_ptr)
          cell_next = IDX[0] ? ptr_new[15:8] : ptr_new[7:0];
      end

      // No I/O bus term reaches a working register
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
          regs_reg[gi] <= 8'h00;
        else
          regs_reg[gi] <= cell_next;
      end
    end
  endgenerate

  // Shared temporary byte for 16-bit accesses
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      temp_reg <= 8'h00;
    else if (io_wr && io_addr == AW'(crg_pkg::OFS_SP_LO))
    begin
      temp_reg <= io_wdata;
    end
    else if (io_wr && io_addr == AW'(crg_pkg::OFS_TEMP))
    begin
      temp_reg <= io_wdata;
    end
    else if (io_rd && io_addr == AW'(crg_pkg::OFS_SP_LO))
    begin
      temp_reg <= sp_reg[15:8];
    end
  end

  // Stack pointer takes both halves at the high byte write
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      sp_reg <= crg_pkg::SP_RESET;
    else if (io_wr && io_addr == AW'(crg_pkg::OFS_SP_HI))
      sp_reg <= {io_wdata, temp_reg};
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      flags_reg <= crg_pkg::FLAGS_RESET;
    else if (io_wr && io_addr == AW'(crg_pkg::OFS_FLAGS))
      flags_reg <= io_wdata;
  end

  assign wr_guard = io_wr && io_addr == AW'(crg_pkg::OFS_GUARD);
  assign sig_io   = wr_guard && io_wdata == crg_pkg::SIG_IO_UNLOCK;
  assign sig_sp   = wr_guard && io_wdata == crg_pkg::SIG_SELF_PROG;

  // Cancel events differ per mode; the unlocking write itself is not one of them
  always_comb
  begin
    case (guard_reg)
      crg_pkg::CRG_IO_OPEN:
        guard_cancel = data_write || io_wr || nvm_access || sleep_exec;
      crg_pkg::CRG_SP_OPEN:
        guard_cancel = nvm_access || sleep_exec || spm_exec;
      default:
        guard_cancel = 1'b0;
    endcase
  end

  assign guard_tick = insn_done && guard_reg != crg_pkg::CRG_IDLE;
  assign guard_last = guard_tick && guard_cnt_reg == 3'h1;

  // Window state; a fresh signature wins over a cancel in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      guard_reg <= crg_pkg::CRG_IDLE;
    else if (sig_io)
      guard_reg <= crg_pkg::CRG_IO_OPEN;
    else if (sig_sp)
      guard_reg <= crg_pkg::CRG_SP_OPEN;
    else
    begin
      case (guard_reg)
        crg_pkg::CRG_IO_OPEN:
        begin
          if (guard_cancel || guard_last)
            guard_reg <= crg_pkg::CRG_IDLE;
        end
        crg_pkg::CRG_SP_OPEN:
        begin
          if (guard_cancel || guard_last)
            guard_reg <= crg_pkg::CRG_IDLE;
        end
        default:
          guard_reg <= crg_pkg::CRG_IDLE;
      endcase
    end
  end

  // Instructions left in the open window
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      guard_cnt_reg <= 3'h0;
    else if (sig_io || sig_sp)
      guard_cnt_reg <= crg_pkg::GUARD_INSNS;
    else if (guard_reg == crg_pkg::CRG_IDLE)
      guard_cnt_reg <= 3'h0;
    else if (guard_tick && !guard_cancel)
      guard_cnt_reg <= guard_cnt_reg - 3'h1;
  end

  assign prot_write_ok = prot_write_req && guard_reg == crg_pkg::CRG_IO_OPEN;
  assign spm_ok        = spm_exec && guard_reg == crg_pkg::CRG_SP_OPEN;
  assign irq_hold      = guard_reg != crg_pkg::CRG_IDLE;

  // Byte bus read mux; unmapped offsets read zero
  always_comb
  begin
    io_rd_mux = 8'h00;
    if (io_addr == AW'(crg_pkg::OFS_GUARD))
    begin
      io_rd_mux[crg_pkg::GUARD_IO_BIT] = guard_reg == crg_pkg::CRG_IO_OPEN;
      io_rd_mux[crg_pkg::GUARD_SP_BIT] = guard_reg == crg_pkg::CRG_SP_OPEN;
    end
    else if (io_addr == AW'(crg_pkg::OFS_SP_LO))
    begin
      io_rd_mux = sp_reg[7:0];
    end
    else if (io_addr == AW'(crg_pkg::OFS_SP_HI))
    begin
      io_rd_mux = temp_reg;
    end
    else if (io_addr == AW'(crg_pkg::OFS_TEMP))
    begin
      io_rd_mux = temp_reg;
    end
    else if (io_addr == AW'(crg_pkg::OFS_FLAGS))
    begin
      io_rd_mux = flags_reg;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      io_rdata_reg <= 8'h00;
    else if (io_rd)
      io_rdata_reg <= io_rd_mux;
  end

  assign io_rdata      = io_rdata_reg;
  assign flags         = flags_reg;
  assign stack_pointer = sp_reg;
endmodule : crg_core

// [bench/crg_core_chk.sv]
// Port checker for the register file and change guard
`timescale 1ns/100ps
module crg_core_chk #(
  parameter int AW = 6
) (
  // Clock and reset
  input wire logic mclk, rst_n,
  // Register file
  input wire logic wr_byte_en, wr_word_en, dbg_halt,
  input wire logic [4:0] rd_a_idx, wr_idx,
  input wire logic [7:0] rd_a_data,
  input wire logic [15:0] wr_data, stack_pointer,
  // Guard and I/O bus
  input wire logic io_wr, io_rd, insn_done, nvm_access, sleep_exec,
  input wire logic irq_hold, prot_write_ok, spm_ok,
  input wire logic [AW-1:0] io_addr,
  input wire logic [7:0] io_wdata, io_rdata
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire g = io_wr && io_addr == crg_pkg::OFS_GUARD;
  wire sig = io_wdata == crg_pkg::SIG_IO_UNLOCK || io_wdata == crg_pkg::SIG_SELF_PROG;
  a_byte_write:
    assert property ($past(rst_n && wr_byte_en && !wr_word_en && !dbg_halt) && rd_a_idx == $past(wr_idx)
      |-> rd_a_data == $past(wr_data[7:0])) else $error("byte write lost");
  a_sp_commit:
    assert property (io_wr && io_addr == crg_pkg::OFS_SP_LO ##1 io_wr && io_addr == crg_pkg::OFS_SP_HI
      |=> stack_pointer == {$past(io_wdata), $past(io_wdata, 2)}) else $error("pair commit wrong");
  a_sp_copy:
    assert property (io_rd && io_addr == crg_pkg::OFS_SP_LO ##1 io_rd && io_addr == crg_pkg::OFS_SP_HI
      |=> io_rdata == $past(stack_pointer[15:8], 2)) else $error("high byte not copied");
  a_guard_open:
    assert property (g && (sig || !irq_hold) |=> irq_hold == $past(sig)) else $error("guard window wrong");
  a_guard_count:
    assert property (g && io_wdata == crg_pkg::SIG_IO_UNLOCK ##1 (insn_done && !g)[*4] |=> !irq_hold)
      else $error("window too long");
  a_guard_cancel:
    assert property ((nvm_access || sleep_exec) && !g |=> !irq_hold) else $error("cancel ignored");
  a_grant_gated:
    assert property (prot_write_ok || spm_ok |-> irq_hold) else $error("grant while closed");
  a_guard_bits:
    assert property (io_rd && io_addr == crg_pkg::OFS_GUARD |=> io_rdata[7:2] == 6'h00
      && (|io_rdata[1:0]) == $past(irq_hold)) else $error("guard read wrong");
  c_io_grant: cover property (prot_write_ok);
  c_spm_grant: cover property (spm_ok);
  c_close: cover property (irq_hold ##1 !irq_hold);
endmodule : crg_core_chk
bind crg_core crg_core_chk #(.AW(AW)) u_chk (.*);

// [bench/crg_bus_model.sv]
// Execution-side driver of the I/O bus and instruction stream
`timescale 1ns/100ps
module crg_bus_model (
  // Clock
  input wire logic mclk,
  // Requests toward the block
  output logic io_wr = 1'b0, io_rd = 1'b0, insn_done = 1'b0,
  output logic [5:0] io_addr = 6'h00,
  output logic [7:0] io_wdata = 8'h00,
  // Read data of the previous request
  input wire logic [7:0] io_rdata,
  output logic [7:0] rdq = 8'h00
);
  // One request a cycle; callers send low bytes first, protected writes soon after unlock
  task op(input logic w, r, input logic [5:0] a, input logic [7:0] d, input logic i);
    @(negedge mclk);
    rdq = io_rdata;
    io_wr = w;
    io_rd = r;
    insn_done = i;
    // Released lines toggle so no stale value looks valid
    io_addr = (w || r) ? a : ~io_addr;
    io_wdata = w ? d : ~io_wdata;
  endtask : op
endmodule : crg_bus_model

// [bench/tb_crg_core.sv]
// Self-checking bench for the register file and change guard
`timescale 1ns/100ps
module tb_crg_core;
  logic mclk = 1'b0, rst_n = 1'b0, wr_byte_en = 1'b0, wr_word_en = 1'b0, ptr_use = 1'b0;
  logic prog_ptr_use = 1'b0, nvm_access = 1'b0, sleep_exec = 1'b0, spm_exec = 1'b0, prot_write_req = 1'b0;
  logic data_write = 1'b0, dbg_halt = 1'b0, dbg_wr = 1'b0;
  logic [4:0] rd_a_idx = 5'h00, wr_idx = 5'h00, rd_b_idx = 5'h00, dbg_idx = 5'h00;
  logic [7:0] dbg_wdata = 8'h00, rd_b_data, flags, dbg_rdata;
  logic [15:0] wr_data = 16'h0000;
  logic [1:0] ptr_sel = 2'h0, ptr_mode = 2'h3;
  logic [5:0] ptr_disp = 6'h00, io_addr;
  logic io_wr, io_rd, insn_done, prot_write_ok, spm_ok, irq_hold;
  logic [7:0] io_wdata, io_rdata, rdq, rd_a_data;
  logic [15:0] rd_word_data, ptr_addr, prog_addr, stack_pointer;
  logic [7:0] sg [3] = '{8'hD8, 8'h9D, 8'h55};
  logic [1:0] ex [3] = '{2'h1, 2'h2, 2'h0};
  int n_errors = 0, checks_done = 0;
  crg_core DUT (.*);
  crg_bus_model bm (.*);
  always #12.5 mclk = ~mclk;
  task chk(input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task o(input logic w, r, input logic [5:0] a, input logic [7:0] d);
    bm.op(w, r, a, d, 1'b0);
  endtask : o
  task end_sim;
    $display("Checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (2000) @(posedge mclk);
    n_errors++;
    end_sim();
  end
  initial
  begin
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    o('0, '1, crg_pkg::OFS_SP_LO, 8'h00);
    o('0, '1, crg_pkg::OFS_SP_HI, 8'h00);
    chk(rdq, crg_pkg::SP_RESET[7:0]);
    o('0, '1, crg_pkg::OFS_GUARD, 8'h00);
    chk(rdq, crg_pkg::SP_RESET[15:8]);
    o('0, '0, 6'h00, 8'h00);
    chk(rdq, 16'h0000);
    $display("Test reset done");
    for (int i = 0; i < 32; i++)
    begin
      @(negedge mclk);
      wr_byte_en = 1'b1;
      wr_idx = i[4:0];
      wr_data = {8'h00, i[7:0] ^ 8'hA5};
      rd_a_idx = i[4:0] - 5'h01;
      #1;
      if (i > 0)
        chk(rd_a_data, {8'h00, (i[7:0] - 8'h01) ^ 8'hA5});
    end
    @(negedge mclk);
    wr_word_en = 1'b1;
    wr_idx = crg_pkg::PTR3_LO;
    wr_data = 16'h1234;
    rd_a_idx = 5'h1F;
    rd_b_idx = 5'h03;
    #1;
    chk(rd_a_data, 16'h00BA);
    chk(rd_b_data, 16'h00A6);
    @(negedge mclk);
    wr_byte_en = 1'b0;
    wr_idx = crg_pkg::PTR1_LO;
    wr_data = 16'h0100;
    rd_a_idx = crg_pkg::PTR3_LO;
    prog_ptr_use = 1'b1;
    #1;
    chk(rd_word_data, 16'h1234);
    chk(prog_addr, 16'h1234);
    @(negedge mclk);
    wr_word_en = 1'b0;
    ptr_mode = crg_pkg::MODE_DISP;
    ptr_disp = 6'h3F;
    #1;
    chk(ptr_addr, 16'h013F);
    ptr_mode = crg_pkg::MODE_PREDEC;
    #1;
    chk(ptr_addr, 16'h00FF);
    ptr_mode = crg_pkg::MODE_POSTINC;
    ptr_use = 1'b1;
    @(negedge mclk);
    ptr_use = 1'b0;
    rd_a_idx = crg_pkg::PTR1_LO;
    ptr_sel = 2'h2;
    #1;
    chk(rd_word_data, 16'h0101);
    chk(ptr_addr, 16'h1234);
    @(negedge mclk);
    dbg_halt = 1'b1;
    dbg_wr = 1'b1;
    dbg_idx = 5'h05;
    dbg_wdata = 8'h77;
    wr_byte_en = 1'b1;
    wr_idx = 5'h05;
    @(negedge mclk);
    dbg_wr = 1'b0;
    wr_byte_en = 1'b0;
    #1;
    chk(dbg_rdata, 16'h0077);
    dbg_halt = 1'b0;
    $display("Test regfile done");
    o('1, '0, crg_pkg::OFS_SP_LO, 8'h12);
    o('1, '0, crg_pkg::OFS_SP_HI, 8'h34);
    o('1, '0, crg_pkg::OFS_SP_LO, 8'h56);
    o('0, '1, crg_pkg::OFS_SP_LO, 8'h00);
    chk(stack_pointer, 16'h3412);
    o('0, '1, crg_pkg::OFS_SP_HI, 8'h00);
    chk(rdq, 16'h0012);
    o('1, '0, crg_pkg::OFS_TEMP, 8'h5A);
    chk(rdq, 16'h0034);
    o('0, '1, crg_pkg::OFS_TEMP, 8'h00);
    o('0, '1, 6'h01, 8'h00);
    chk(rdq, 16'h005A);
    o('1, '0, crg_pkg::OFS_FLAGS, 8'hC3);
    chk(rdq, 16'h0000);
    o('0, '1, crg_pkg::OFS_FLAGS, 8'h00);
    o('0, '0, 6'h00, 8'h00);
    chk(rdq, 16'h00C3);
    chk(flags, 16'h00C3);
    $display("Test stack pointer done");
    for (int k = 0; k < 3; k++)
    begin
      o('1, '0, crg_pkg::OFS_GUARD, sg[k]);
      o('0, '1, crg_pkg::OFS_GUARD, 8'h00);
      o('0, '0, 6'h00, 8'h00);
      prot_write_req = 1'b1;
      spm_exec = 1'b1;
      #1;
      chk(rdq, ex[k]);
      chk(irq_hold, |ex[k]);
      chk(prot_write_ok, ex[k][0]);
      chk(spm_ok, ex[k][1]);
      prot_write_req = 1'b0;
      spm_exec = 1'b0;
      nvm_access = k[0];
      sleep_exec = !k[0];
      o('0, '0, 6'h00, 8'h00);
      nvm_access = 1'b0;
      sleep_exec = 1'b0;
      chk(irq_hold, 16'h0000);
    end
    o('1, '0, crg_pkg::OFS_GUARD, crg_pkg::SIG_IO_UNLOCK);
    repeat (4) bm.op('0, '0, 6'h00, 8'h00, '1);
    chk(irq_hold, 16'h0001);
    o('0, '0, 6'h00, 8'h00);
    chk(irq_hold, 16'h0000);
    o('1, '0, crg_pkg::OFS_GUARD, crg_pkg::SIG_IO_UNLOCK);
    o('1, '0, crg_pkg::OFS_TEMP, 8'h00);
    o('0, '0, 6'h00, 8'h00);
    chk(irq_hold, 16'h0000);
    o('1, '0, crg_pkg::OFS_GUARD, crg_pkg::SIG_IO_UNLOCK);
    o('0, '0, 6'h00, 8'h00);
    chk(irq_hold, 16'h0001);
    data_write = 1'b1;
    o('0, '0, 6'h00, 8'h00);
    data_write = 1'b0;
    chk(irq_hold, 16'h0000);
    $display("Test guard done");
    end_sim();
  end
endmodule : tb_crg_core
